// ---- hw/sfvp_top.sv ----
// Purpose: Vendor parameter area reads and power-on state of a serial flash.
// Assumes: Serial framing is decoded upstream; a read request carries lane mode and byte address.
// Notes:   The delay count is a parameter so simulation can shorten it.
//
// Notes on behaviour
// RULE1: Bytes 60h and 61h read 00h and 36h, a maximum supply of 3.600 V.
// RULE2: Bytes 62h and 63h read 50h and 23h, a minimum supply of 2.350 V.
// RULE3: The word at 64h reads 4ff6h with reset pin absent, hold present, deep power-down present, no soft reset.
// RULE4: In that word the soft-reset opcode field is all ones, suspends read zero, bit 14 one, wrap-around zero.
// RULE5: Bytes 66h and 67h read ffh because wrap-around reads are not offered.
// RULE6: The low half of the word at 68h reads c7feh describing the lock features.
// RULE7: Bits 11 to 13 of that word read zero, bits 15:14 read ones and bits 31:16 read all ones.
// RULE8: Bytes 6ch to 6fh and every undefined location read ffh.
// RULE9: The parameter read is only served in uniform single, dual or quad lane mode.
// RULE10: Wait states are dummy clocks after the address or mode bits, counted by the framer.
// RULE11: The host drives any mode bits right after the address.
// RULE12: After power-up the device is in standby, not deep power-down, with the write latch cleared.
// RULE13: The host keeps select inactive through power-up until the delay has passed.
// RULE14: Commands are accepted only once the power-up select delay has elapsed.
// RULE15: While power-on reset is active all serial activity is ignored and outputs stay off.
`timescale 1ns/100ps
module sfvp_top
  import sfvp_pkg::*;
#(
  parameter int DELAY_CYC = SFVP_SELECT_DELAY_CYC
)(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  // Read request from the serial framer
  input  wire logic       i_rd_req,
  input  wire logic [1:0] i_rd_lanes,
  input  wire logic [7:0] i_rd_addr,
  // Write-latch control from the command decoder
  input  wire logic       i_wel_set,
  input  wire logic       i_wel_clr,
  // Read answer
  output logic            o_rd_valid,
  output logic      [7:0] o_rd_data,
  output logic            o_rd_oe,
  // Power state
  output logic            o_ready,
  output logic            o_deep_power_down,
  output logic            o_write_latch_flag
);

  // Lane modes accepted by the parameter read, lowest code first.
  localparam int                         LANE_W     = $bits(SFVP_LANES_SINGLE);
  localparam int                         LANE_CNT   = 3;
  localparam logic [LANE_CNT*LANE_W-1:0] LANE_TABLE = {SFVP_LANES_QUAD, SFVP_LANES_DUAL, SFVP_LANES_SINGLE};

  // A zero delay would wrap the terminal count, so it is clamped to a single cycle.
  localparam int                         DELAY_LAST = (DELAY_CYC > 0) ? (DELAY_CYC - 1) : 0;

  typedef struct packed {
    sfvp_pwr_type pwr;
    logic [31:0]  cnt;
    logic         rd_valid;
    logic [7:0]   rd_data;
    logic         rd_oe;
    logic         ready;
    logic         dpd;
    logic         write_latch_flag;
  } sfvp_state_type;

  sfvp_state_type      state_reg;
  sfvp_state_type      state_next;
  logic [7:0]          rom_data;
  logic [LANE_CNT-1:0] lane_hit;
  logic                lanes_ok;
  logic                in_standby;
  logic                in_wait;
  logic                delay_done;
  logic                read_take;
  logic                latch_set;
  logic                latch_clr;

  sfvp_rom u_rom (
    .i_addr (i_rd_addr),
    .o_data (rom_data)
  );

  for (genvar g = 0; g < LANE_CNT; g++) begin : g_lane
    assign lane_hit[g] = (i_rd_lanes == LANE_TABLE[g*LANE_W +: LANE_W]); // RULE9
  end

  assign lanes_ok   = |lane_hit; // RULE9

  assign in_standby = (state_reg.pwr == SFVP_ST_STANDBY);
  assign in_wait    = (state_reg.pwr == SFVP_ST_WAIT);
  assign delay_done = in_wait && (state_reg.cnt >= 32'(DELAY_LAST)); // RULE14

  // Requests count only in standby, so anything seen during reset or the delay is dropped, not answered stale.
  assign read_take  = in_standby && i_rd_req && lanes_ok; // RULE9 RULE14 RULE15
  assign latch_set  = in_standby && i_wel_set;
  assign latch_clr  = in_standby && i_wel_clr;

  always_comb begin
    state_next          = state_reg;
    state_next.rd_valid = 1'b0;
    state_next.rd_oe    = 1'b0; // RULE15
    state_next.dpd      = 1'b0; // RULE12
    case (state_reg.pwr)
      SFVP_ST_POR: begin
        state_next.cnt   = 32'h0;
        state_next.ready = 1'b0;
        state_next.write_latch_flag   = 1'b0; // RULE12
        state_next.pwr   = SFVP_ST_WAIT; // RULE15
      end
      SFVP_ST_WAIT: begin
        if (delay_done) begin
          state_next.pwr   = SFVP_ST_STANDBY;
          state_next.ready = 1'b1; // RULE14
        end else begin
          state_next.cnt   = state_reg.cnt + 32'h1;
        end
      end
      SFVP_ST_STANDBY: begin
        // The framer raises the request after any dummy clocks, so the answer goes out on the next edge.
        if (read_take) begin
          state_next.rd_valid = 1'b1; // RULE10
          state_next.rd_oe    = 1'b1;
          state_next.rd_data  = rom_data;
        end
        // Set wins over clear when both arrive in the same cycle, so the clear is dropped.
        if (latch_set) begin
          state_next.write_latch_flag = 1'b1;
        end else if (latch_clr) begin
          state_next.write_latch_flag = 1'b0;
        end
      end
      default: begin
        state_next.pwr   = SFVP_ST_POR;
        state_next.ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg.pwr      <= SFVP_ST_POR;
      state_reg.cnt      <= 32'h0;
      state_reg.rd_valid <= 1'b0;
      state_reg.rd_data  <= 8'h0;
      state_reg.rd_oe    <= 1'b0; // RULE15
      state_reg.ready    <= 1'b0;
      state_reg.dpd      <= 1'b0; // RULE12
      state_reg.write_latch_flag      <= 1'b0; // RULE12
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rd_valid         = state_reg.rd_valid;
  assign o_rd_data          = state_reg.rd_data;
  assign o_rd_oe            = state_reg.rd_oe;
  assign o_ready            = state_reg.ready;
  assign o_deep_power_down  = state_reg.dpd; // RULE12
  assign o_write_latch_flag = state_reg.write_latch_flag;

endmodule : sfvp_top

// ---- hw/sfvp_pkg.sv ----
// Purpose: Constants for the vendor parameter area and power-on sequencing.
// Assumes: Byte addresses are the parameter-space byte offsets.
// Notes:   Values are the fixed read-only contents of the area.
package sfvp_pkg;

  localparam logic [7:0]  SFVP_ADDR_SUPPLY_MAX   = 8'h60;
  localparam logic [7:0]  SFVP_ADDR_SUPPLY_MIN   = 8'h62;
  localparam logic [7:0]  SFVP_ADDR_PIN_FEATURE  = 8'h64;
  localparam logic [7:0]  SFVP_ADDR_WRAP_OPCODE  = 8'h66;
  localparam logic [7:0]  SFVP_ADDR_WRAP_LENGTH  = 8'h67;
  localparam logic [7:0]  SFVP_ADDR_LOCK_FEATURE = 8'h68;
  localparam logic [7:0]  SFVP_ADDR_TAIL         = 8'h6c;

  localparam logic [15:0] SFVP_SUPPLY_MAX_VAL    = 16'h3600;
  localparam logic [15:0] SFVP_SUPPLY_MIN_VAL    = 16'h2350;
  localparam logic [15:0] SFVP_PIN_FEATURE_VAL   = 16'h4ff6;
  localparam logic [7:0]  SFVP_WRAP_OPCODE_VAL   = 8'hff;
  localparam logic [7:0]  SFVP_WRAP_LENGTH_VAL   = 8'hff;
  localparam logic [31:0] SFVP_LOCK_FEATURE_VAL  = 32'hffffc7fe;
  localparam logic [7:0]  SFVP_BLANK_BYTE        = 8'hff;

  // Power-up select delay in microseconds and its cycle count at 100 MHz.
  localparam int          SFVP_CLK_MHZ           = 100;
  localparam int          SFVP_SELECT_DELAY_US   = 800;
  localparam int          SFVP_SELECT_DELAY_CYC  = SFVP_SELECT_DELAY_US * SFVP_CLK_MHZ;

  // Lane modes accepted for the parameter-read instruction.
  localparam logic [1:0]  SFVP_LANES_SINGLE      = 2'h0;
  localparam logic [1:0]  SFVP_LANES_DUAL        = 2'h1;
  localparam logic [1:0]  SFVP_LANES_QUAD        = 2'h2;

  typedef enum logic [1:0] {
    SFVP_ST_POR,
    SFVP_ST_WAIT,
    SFVP_ST_STANDBY
  } sfvp_pwr_type;

endpackage : sfvp_pkg

// ---- hw/sfvp_rom.sv ----
// Purpose: Combinational byte lookup of the vendor parameter area.
// Assumes: Address is a byte address in the parameter space.
// Notes:   Every byte not defined reads as blank.
`timescale 1ns/100ps
module sfvp_rom
  import sfvp_pkg::*;
(
  // Lookup
  input  wire logic [7:0] i_addr,
  output logic      [7:0] o_data
);

  always_comb begin
    case (i_addr)
      SFVP_ADDR_SUPPLY_MAX:           o_data = SFVP_SUPPLY_MAX_VAL[7:0];     // RULE1
      SFVP_ADDR_SUPPLY_MAX + 8'h01:   o_data = SFVP_SUPPLY_MAX_VAL[15:8];    // RULE1
      SFVP_ADDR_SUPPLY_MIN:           o_data = SFVP_SUPPLY_MIN_VAL[7:0];     // RULE2
      SFVP_ADDR_SUPPLY_MIN + 8'h01:   o_data = SFVP_SUPPLY_MIN_VAL[15:8];    // RULE2
      SFVP_ADDR_PIN_FEATURE:          o_data = SFVP_PIN_FEATURE_VAL[7:0];    // RULE3
      SFVP_ADDR_PIN_FEATURE + 8'h01:  o_data = SFVP_PIN_FEATURE_VAL[15:8];   // RULE4
      SFVP_ADDR_WRAP_OPCODE:          o_data = SFVP_WRAP_OPCODE_VAL;         // RULE5
      SFVP_ADDR_WRAP_LENGTH:          o_data = SFVP_WRAP_LENGTH_VAL;         // RULE5
      SFVP_ADDR_LOCK_FEATURE:         o_data = SFVP_LOCK_FEATURE_VAL[7:0];   // RULE6
      SFVP_ADDR_LOCK_FEATURE + 8'h01: o_data = SFVP_LOCK_FEATURE_VAL[15:8];  // RULE7
      SFVP_ADDR_LOCK_FEATURE + 8'h02: o_data = SFVP_LOCK_FEATURE_VAL[23:16]; // RULE7
      SFVP_ADDR_LOCK_FEATURE + 8'h03: o_data = SFVP_LOCK_FEATURE_VAL[31:24]; // RULE7
      default:                        o_data = SFVP_BLANK_BYTE;              // RULE8
    endcase
  end

endmodule : sfvp_rom

// ---- dv/sfvp_monitor.sv ----
// Purpose: Port checker for sfvp_top.
// Assumes: One clock.
// Notes:   Bound from the bench top file.
`timescale 1ns/100ps
module sfvp_top_monitor
  import sfvp_pkg::*;
(
  // Watched ports
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_rd_req,
  input wire logic [1:0] i_rd_lanes,
  input wire logic [7:0] i_rd_addr,
  input wire logic       i_wel_set,
  input wire logic       i_wel_clr,
  input wire logic       o_rd_valid,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rd_oe,
  input wire logic       o_ready,
  input wire logic       o_deep_power_down,
  input wire logic       o_write_latch_flag
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  a_read_answered: assert property (i_rd_req && o_ready && i_rd_lanes != 2'h3 |=> o_rd_valid && o_rd_oe)
    else $error("read not answered");
  a_bad_lanes: assert property (i_rd_req && i_rd_lanes == 2'h3 |=> !o_rd_valid) else $error("bad lanes");
  a_answer_cause: assert property (o_rd_oe |-> $past(i_rd_req) && $past(o_ready)) else $error("stray");
  a_max_top: assert property (o_rd_valid && $past(i_rd_addr) == 8'h61 |-> o_rd_data == 8'h36)
    else $error("byte 61");
  a_min_top: assert property (o_rd_valid && $past(i_rd_addr) == 8'h63 |-> o_rd_data == 8'h23)
    else $error("byte 63");
  a_blank_tail: assert property (o_rd_valid && $past(i_rd_addr) >= 8'h6c |-> o_rd_data == 8'hff)
    else $error("blank byte");
  a_no_deep_down: assert property (!o_deep_power_down) else $error("deep down");
  a_latch_next: assert property (o_ready && (i_wel_set || i_wel_clr) |=> o_write_latch_flag == $past(i_wel_set))
    else $error("latch");
endmodule : sfvp_top_monitor

// ---- dv/sfvp_host_model.sv ----
// Purpose: Host controller issuing byte reads.
// Assumes: Falling-edge drive.
// Notes:   Early sends break the select rules on purpose.
`timescale 1ns/100ps
module sfvp_host_model (
  // Bus
  input  wire logic       i_core_clk,
  input  wire logic       i_ready,
  output logic            o_req,
  output logic      [1:0] o_lanes,
  output logic      [7:0] o_addr
);
  initial begin
    o_req = 1'b0;
    o_lanes = 2'h0;
    o_addr = 8'h00;
  end
  task automatic send(input logic [7:0] addr, input logic [1:0] lanes, input logic early);
    while (!early && i_ready !== 1'b1) @(negedge i_core_clk);
    @(negedge i_core_clk);
    o_req = 1'b1;
    o_addr = addr;
    o_lanes = lanes;
    @(negedge i_core_clk);
    o_req = 1'b0;
    // The released address shows the inverse so a stale value cannot pass; the lanes keep their value.
    o_addr = ~addr;
  endtask : send
endmodule : sfvp_host_model

// ---- dv/sfvp_top_tb_top.sv ----
// Purpose: Self-checking bench for sfvp_top.
// Assumes: Delay of 10 cycles.
// Notes:   Inputs move on falling edges.
`timescale 1ns/100ps
module sfvp_top_tb_top;
  import sfvp_pkg::*;
  localparam logic [127:0] EXP = 128'hffff_ffff_ffff_c7fe_ffff_4ff6_2350_3600;
  logic       i_core_clk, i_sys_rst, i_rd_req, i_wel_set, i_wel_clr, o_rd_valid, o_rd_oe;
  logic       o_ready, o_deep_power_down, o_write_latch_flag;
  logic [1:0] i_rd_lanes;
  logic [7:0] i_rd_addr, o_rd_data;
  int         miscompares = 0, checks = 0, cycles = 0;
  sfvp_top #(.DELAY_CYC(10)) dut_u (
    .i_core_clk         (i_core_clk),
    .i_sys_rst          (i_sys_rst),
    .i_rd_req           (i_rd_req),
    .i_rd_lanes         (i_rd_lanes),
    .i_rd_addr          (i_rd_addr),
    .i_wel_set          (i_wel_set),
    .i_wel_clr          (i_wel_clr),
    .o_rd_valid         (o_rd_valid),
    .o_rd_data          (o_rd_data),
    .o_rd_oe            (o_rd_oe),
    .o_ready            (o_ready),
    .o_deep_power_down  (o_deep_power_down),
    .o_write_latch_flag (o_write_latch_flag)
  );
  sfvp_host_model host_u (.i_core_clk(i_core_clk), .i_ready(o_ready), .o_req(i_rd_req),
                          .o_lanes(i_rd_lanes), .o_addr(i_rd_addr));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [1:0] l, input logic early, input logic want);
    logic [7:0] exp;
    exp = (a >= 8'h60 && a <= 8'h6f) ? EXP[8*(a-8'h60) +: 8] : 8'hff;
    host_u.send(a, l, early);
    // The answer stands one cycle, so it is judged on the falling edge right after the taking edge.
    chk("rd_valid", {7'h0, want}, {7'h0, o_rd_valid});
    chk("rd_oe", {7'h0, want}, {7'h0, o_rd_oe});
    if (want) chk("rd_data", exp, o_rd_data);
  endtask : rd
  task automatic write_latch_flag(input logic s, input logic c, input logic exp);
    @(negedge i_core_clk);
    i_wel_set = s;
    i_wel_clr = c;
    @(negedge i_core_clk);
    i_wel_set = 1'b0;
    i_wel_clr = 1'b0;
    chk("write_latch_flag", {7'h0, exp}, {7'h0, o_write_latch_flag});
  endtask : write_latch_flag
  task automatic t_power_up;
    rd(8'h61, 2'h0, 1'b1, 1'b0);
    write_latch_flag(1'b1, 1'b0, 1'b0);
    chk("ready", 8'h0, {7'h0, o_ready});
    repeat (12) @(negedge i_core_clk);
    chk("ready", 8'h1, {7'h0, o_ready});
    chk("deep_power_down", 8'h0, {7'h0, o_deep_power_down});
  endtask : t_power_up
  task automatic t_table;
    for (int i = 0; i < 18; i++) rd(8'(8'h5f + i), 2'(i % 3), 1'b0, 1'b1);
    rd(8'h60, 2'h3, 1'b0, 1'b0);
  endtask : t_table
  task automatic t_latch_reset;
    write_latch_flag(1'b1, 1'b0, 1'b1);
    write_latch_flag(1'b0, 1'b1, 1'b0);
    write_latch_flag(1'b1, 1'b1, 1'b1);
    i_sys_rst = 1'b1;
    @(negedge i_core_clk);
    chk("reset_latch", 8'h0, {7'h0, o_write_latch_flag});
    chk("reset_ready", 8'h0, {7'h0, o_ready});
    i_sys_rst = 1'b0;
    rd(8'h6f, 2'h2, 1'b0, 1'b1);
  endtask : t_latch_reset
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    i_sys_rst = 1'b1;
    i_wel_set = 1'b0;
    i_wel_clr = 1'b0;
    repeat (3) @(negedge i_core_clk);
    i_sys_rst = 1'b0;
    t_power_up();
    t_table();
    t_latch_reset();
    wrap_up();
  end
endmodule : sfvp_top_tb_top
bind sfvp_top sfvp_top_monitor mon_u (
  .i_core_clk         (i_core_clk),
  .i_sys_rst          (i_sys_rst),
  .i_rd_req           (i_rd_req),
  .i_rd_lanes         (i_rd_lanes),
  .i_rd_addr          (i_rd_addr),
  .i_wel_set          (i_wel_set),
  .i_wel_clr          (i_wel_clr),
  .o_rd_valid         (o_rd_valid),
  .o_rd_data          (o_rd_data),
  .o_rd_oe            (o_rd_oe),
  .o_ready            (o_ready),
  .o_deep_power_down  (o_deep_power_down),
  .o_write_latch_flag (o_write_latch_flag)
);
